// *** verilog/conversion_clock_select_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Conversion clock select 00/10/11 gives 24/96/48 half-periods; 01 reserved.
// - Sample clock select gives one, two, four or eight conversion clocks.
// - Sampling lasts exactly two sample clock periods.
// - Total time is fourteen conversion clocks plus sample time plus four half-periods.
// - Input below ground gives 000; above upper reference gives 3FF.
// - After sampling the held value alone decides the result.
// - All timing counts in half-periods of the CPU clock.
module conversion_clock_select_ctrl
    import conversion_clock_select_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic              i_start,
    input  wire conversion_clock_select_cfg_t        i_cfg,
    input  wire conversion_clock_select_ain_t        i_ain,
    output logic                   o_busy,
    output logic                   o_sampling,
    output logic                   o_done,
    output logic [CONVERSION_CLOCK_SELECT_RES_W-1:0] o_result
);
    typedef struct packed
    {
        conversion_clock_select_state_t state;
        conversion_clock_select_cfg_t   cfg;
        conversion_clock_select_ain_t   ain_s1;
        conversion_clock_select_ain_t   ain_s2;
        // Value frozen when sampling ends; the conversion reads only this.
        conversion_clock_select_ain_t   held;
        // Sampling can span sixteen conversion clocks, hence five bits.
        logic [4:0]   sc_left;
        logic [3:0]   cc_left;
        logic [1:0]   load_left;
        logic         reload;
        logic         busy;
        logic         sampling;
        logic         done;
        logic [9:0]   result;
    } conversion_clock_select_st_t;

    conversion_clock_select_st_t   st_r;
    conversion_clock_select_st_t   st_nxt;
    logic        cc_tick;
    logic [15:0] cc_period;
    logic [4:0]  sample_ticks;
    logic        sample_last;
    logic        conv_last;
    logic        load_last;

    // Sample clock in conversion clocks is 1 << select.
    function automatic logic [3:0] conversion_clock_select_sc_mult(input logic [1:0] sel);
        return 4'h1 << sel;
    endfunction : conversion_clock_select_sc_mult

    // Sampling spans two sample clocks; the count needs five bits at the slowest
    // setting, where sixteen conversion clocks are counted.
    function automatic logic [4:0] conversion_clock_select_sample_ticks(input logic [1:0] sel);
        logic [4:0] r;
        r = 5'(CONVERSION_CLOCK_SELECT_SAMPLE_SC_COUNT) * 5'(conversion_clock_select_sc_mult(sel));
        return r;
    endfunction : conversion_clock_select_sample_ticks

    // The reserved conversion clock code runs as the fastest setting, so a stray
    // write cannot leave the counters without a defined period.
    function automatic logic [1:0] conversion_clock_select_cc_norm(input logic [1:0] sel);
        logic [1:0] r;
        r = sel;
        if (sel == CONVERSION_CLOCK_SELECT_CC_SEL_RESERVED)
        begin
            r = CONVERSION_CLOCK_SELECT_CC_SEL_24;
        end
        return r;
    endfunction : conversion_clock_select_cc_norm

    // Out-of-range flags beat the raw code, and below ground beats above reference,
    // so a source that trips both comparators still reads as the zero code.
    function automatic logic [CONVERSION_CLOCK_SELECT_RES_W-1:0] conversion_clock_select_clamp(input conversion_clock_select_ain_t a);
        logic [CONVERSION_CLOCK_SELECT_RES_W-1:0] r;
        if (a.below_gnd)
        begin
            r = CONVERSION_CLOCK_SELECT_CODE_MIN;
        end
        else if (a.above_ref)
        begin
            r = CONVERSION_CLOCK_SELECT_CODE_FULL;
        end
        else
        begin
            r = a.code;
        end
        return r;
    endfunction : conversion_clock_select_clamp

    // Period follows the latched field so a mid-conversion write cannot stretch it.
    assign cc_period = conversion_clock_select_cc_cycles(st_r.cfg.conversion_clock_select);

    // Count of conversion clocks that sampling spans, from the live select field.
    assign sample_ticks = conversion_clock_select_sample_ticks(i_cfg.sample_clock_select);

    // Sampling and conversion end on the tick that closes their last counted period, and loading on its last count, so no
    // phase is stretched by the cycle that the state register itself adds.
    assign sample_last = cc_tick && (st_r.sc_left == 5'h01);
    assign conv_last   = cc_tick && (st_r.cc_left == 4'h1);
    assign load_last   = (st_r.load_left == 2'h1);

    // The counter is restarted on every start so that a phase never begins
    // part-way through a conversion clock left over from idle.
    conversion_clock_select_tick u_cc_tick
    (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_reload  (st_r.reload),
        .i_period  (cc_period),
        .o_tick    (cc_tick)
    );

    // Cycle budget from the edge that takes a start: sampling closes two sample
    // clocks later, the fourteenth conversion clock closes after that, and the
    // result lands four half-periods later, when done pulses for one cycle.
    // Half-periods are counted in pairs, since every timing figure here is an
    // even number of half-periods; an odd figure would need the falling edge.
    // The trade is one flip-flop clock domain instead of two.
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.done   = 1'b0;
        st_nxt.reload = 1'b0;
        // Two-stage synchroniser on the pin-side input; only stage two is read.
        // The pin levels may move at any instant, so stage one feeds nothing else.
        st_nxt.ain_s1 = i_ain;
        st_nxt.ain_s2 = st_r.ain_s1;
        case (st_r.state)
            CONVERSION_CLOCK_SELECT_IDLE:
            begin
                // Counters are cleared while idle so that no count survives a run.
                st_nxt.sc_left   = 5'h00;
                st_nxt.cc_left   = 4'h0;
                st_nxt.load_left = 2'h0;
                // Fields are frozen on the start edge; later writes wait for the next run.
                if (i_start)
                begin
                    st_nxt.cfg.conversion_clock_select =
                        conversion_clock_select_cc_norm(i_cfg.conversion_clock_select);
                    st_nxt.cfg.sample_clock_select     = i_cfg.sample_clock_select;
                    st_nxt.sc_left                     = sample_ticks;
                    st_nxt.reload                      = 1'b1;
                    st_nxt.busy                        = 1'b1;
                    st_nxt.sampling                    = 1'b1;
                    st_nxt.state                       = CONVERSION_CLOCK_SELECT_SAMPLE;
                end
            end
            CONVERSION_CLOCK_SELECT_SAMPLE:
            begin
                // The synchronised input is tracked up to the last sampling cycle.
                st_nxt.held = st_r.ain_s2;
                if (cc_tick)
                begin
                    st_nxt.sc_left = st_r.sc_left - 5'h01;
                end
                if (sample_last)
                begin
                    st_nxt.sampling = 1'b0;
                    st_nxt.cc_left  = 4'(CONVERSION_CLOCK_SELECT_CONV_CC_COUNT);
                    st_nxt.state    = CONVERSION_CLOCK_SELECT_CONV;
                end
            end
            CONVERSION_CLOCK_SELECT_CONV:
            begin
                // The held value is not touched again until it is loaded.
                if (cc_tick)
                begin
                    st_nxt.cc_left = st_r.cc_left - 4'h1;
                end
                if (conv_last)
                begin
                    st_nxt.load_left = 2'(CONVERSION_CLOCK_SELECT_LOAD_CYCLES);
                    st_nxt.state     = CONVERSION_CLOCK_SELECT_LOAD;
                end
            end
            CONVERSION_CLOCK_SELECT_LOAD:
            begin
                // Four half-periods of result loading before done is raised.
                st_nxt.load_left = st_r.load_left - 2'h1;
                if (load_last)
                begin
                    st_nxt.result = conversion_clock_select_clamp(st_r.held);
                    st_nxt.done   = 1'b1;
                    st_nxt.busy   = 1'b0;
                    st_nxt.state  = CONVERSION_CLOCK_SELECT_IDLE;
                end
            end
            default:
            begin
                // An unused state code falls back to idle without raising done.
                st_nxt.state = CONVERSION_CLOCK_SELECT_IDLE;
            end
        endcase
    end

    // Reset clears every field, so the outputs read zero and the result reads
    // the zero code until the first conversion completes.
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Every output comes straight from the state register, glitch-free.
    assign o_busy     = st_r.busy;
    assign o_sampling = st_r.sampling;
    assign o_done     = st_r.done;
    assign o_result   = st_r.result;
endmodule : conversion_clock_select_ctrl
`default_nettype wire

// *** verilog/conversion_clock_select_pkg.sv ***
package conversion_clock_select_pkg;

    // Conversion clock select encodings and their length in half-periods.
    localparam logic [1:0] CONVERSION_CLOCK_SELECT_CC_SEL_24       = 2'h0;
    localparam logic [1:0] CONVERSION_CLOCK_SELECT_CC_SEL_RESERVED = 2'h1;
    localparam logic [1:0] CONVERSION_CLOCK_SELECT_CC_SEL_96       = 2'h2;
    localparam logic [1:0] CONVERSION_CLOCK_SELECT_CC_SEL_48       = 2'h3;
    localparam int unsigned CONVERSION_CLOCK_SELECT_CC_HALF_24 = 24;
    localparam int unsigned CONVERSION_CLOCK_SELECT_CC_HALF_96 = 96;
    localparam int unsigned CONVERSION_CLOCK_SELECT_CC_HALF_48 = 48;

    // One system clock period is two half-periods.
    localparam int unsigned CONVERSION_CLOCK_SELECT_HALF_PER_CLK = 2;

    // Sampling lasts two sample clocks; conversion fourteen conversion clocks.
    localparam int unsigned CONVERSION_CLOCK_SELECT_SAMPLE_SC_COUNT = 2;
    localparam int unsigned CONVERSION_CLOCK_SELECT_CONV_CC_COUNT   = 14;
    localparam int unsigned CONVERSION_CLOCK_SELECT_LOAD_HALF       = 4;
    localparam int unsigned CONVERSION_CLOCK_SELECT_LOAD_CYCLES     = CONVERSION_CLOCK_SELECT_LOAD_HALF / CONVERSION_CLOCK_SELECT_HALF_PER_CLK;

    localparam int unsigned CONVERSION_CLOCK_SELECT_RES_W = 10;
    localparam logic [9:0]  CONVERSION_CLOCK_SELECT_CODE_MIN  = 10'h000;
    localparam logic [9:0]  CONVERSION_CLOCK_SELECT_CODE_FULL = 10'h3FF;
    localparam logic [15:0] CONVERSION_CLOCK_SELECT_CNT_RST   = 16'h0000;

    typedef enum logic [1:0]
    {
        CONVERSION_CLOCK_SELECT_IDLE   = 2'b00,
        CONVERSION_CLOCK_SELECT_SAMPLE = 2'b01,
        CONVERSION_CLOCK_SELECT_CONV   = 2'b10,
        CONVERSION_CLOCK_SELECT_LOAD   = 2'b11
    } conversion_clock_select_state_t;

    // Analog input as seen by the digital side: comparator levels and a raw code.
    typedef struct packed
    {
        logic       below_gnd;
        logic       above_ref;
        logic [9:0] code;
    } conversion_clock_select_ain_t;

    typedef struct packed
    {
        logic [1:0] conversion_clock_select;
        logic [1:0] sample_clock_select;
    } conversion_clock_select_cfg_t;

    // Conversion clock length in system clock cycles.
    function automatic logic [15:0] conversion_clock_select_cc_cycles(input logic [1:0] sel);
        logic [15:0] r;
        r = 16'(CONVERSION_CLOCK_SELECT_CC_HALF_24 / CONVERSION_CLOCK_SELECT_HALF_PER_CLK);
        if (sel == CONVERSION_CLOCK_SELECT_CC_SEL_96)
            r = 16'(CONVERSION_CLOCK_SELECT_CC_HALF_96 / CONVERSION_CLOCK_SELECT_HALF_PER_CLK);
        else if (sel == CONVERSION_CLOCK_SELECT_CC_SEL_48)
            r = 16'(CONVERSION_CLOCK_SELECT_CC_HALF_48 / CONVERSION_CLOCK_SELECT_HALF_PER_CLK);
        return r;
    endfunction : conversion_clock_select_cc_cycles

endpackage : conversion_clock_select_pkg

// *** verilog/conversion_clock_select_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
// Down-counter producing a one-cycle tick every period cycles; reload restarts it.
module conversion_clock_select_tick
    import conversion_clock_select_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_reload,
    input  wire logic [15:0] i_period,
    output logic             o_tick
);
    typedef struct packed
    {
        logic [15:0] cnt;
    } conversion_clock_select_tick_st_t;

    conversion_clock_select_tick_st_t st_r;
    conversion_clock_select_tick_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        // A reload request arrives one cycle after the event that caused it, so the
        // counter is loaded one short and the first tick still lands a full period
        // after that event. Periods below two cycles are therefore not supported.
        if (i_reload)
            st_nxt.cnt = i_period - 16'h0001;
        else if (st_r.cnt <= 16'h0001)
            st_nxt.cnt = i_period;
        else
            st_nxt.cnt = st_r.cnt - 16'h0001;
    end

    assign o_tick = !i_reload && (st_r.cnt == 16'h0001);

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule : conversion_clock_select_tick
`default_nettype wire

// *** verification/conversion_clock_select_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module conversion_clock_select_src
    import conversion_clock_select_pkg::*;
(
    input  wire logic signed [11:0] i_lvl,
    output var  conversion_clock_select_ain_t         o_ain
);
    // The raw code is passed on even out of range, so that only the device's clamp can save it.
    always_comb
    begin
        o_ain.below_gnd = i_lvl < 0;
        o_ain.above_ref = i_lvl > 12'sh3FF;
        o_ain.code      = i_lvl[9:0];
    end
endmodule : conversion_clock_select_src
`default_nettype wire

// *** verification/conversion_clock_select_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module conversion_clock_select_ctrl_asserts
    import conversion_clock_select_pkg::*;
(
    input wire logic                   i_sys_clk,
    input wire logic                   i_rst,
    input wire logic                   i_start,
    input wire conversion_clock_select_cfg_t             i_cfg,
    input wire logic                   o_busy,
    input wire logic                   o_sampling,
    input wire logic                   o_done,
    input wire logic [CONVERSION_CLOCK_SELECT_RES_W-1:0] o_result
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    conversion_clock_select_cfg_t  cfg_r;
    logic [15:0] samp_r;
    logic [15:0] tot_r;
    logic [15:0] cc;
    always_comb
        cc = (cfg_r[3:2] == 2'h2) ? 16'h0030 : (cfg_r[3:2] == 2'h3) ? 16'h0018 : 16'h000C;
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            samp_r <= 16'h0000;
            tot_r  <= 16'h0000;
            cfg_r  <= '0;
        end
        else
        begin
            samp_r <= o_sampling ? samp_r + 16'h0001 : 16'h0000;
            tot_r  <= o_busy ? tot_r + 16'h0001 : 16'h0000;
            if (i_start && !o_busy && !o_done)
                cfg_r <= i_cfg;
        end
    end
    sequence conv_begin;
        o_busy && o_sampling;
    endsequence
    start_taken_a: assert property (i_start && !o_busy && !o_done |=> conv_begin)
        else $error("start not taken");
    samp_len_a: assert property ($fell(o_sampling) |-> samp_r == (cc << (cfg_r[1:0] + 1)))
        else $error("sample phase length wrong");
    conv_len_a: assert property (o_done |-> tot_r == cc * 16'h000E + (cc << (cfg_r[1:0] + 1)) + 16'h0002)
        else $error("conversion length wrong");
    done_pulse_a: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    done_idle_a: assert property (o_done |-> !o_busy && !o_sampling)
        else $error("done while busy");
    samp_busy_a: assert property (o_sampling |-> o_busy)
        else $error("sampling outside busy");
    result_hold_a: assert property (!o_done |-> $stable(o_result))
        else $error("result changed without done");
    busy_first_a: assert property ($rose(o_busy) |-> o_sampling)
        else $error("busy without sampling");
endmodule : conversion_clock_select_ctrl_asserts
bind conversion_clock_select_ctrl conversion_clock_select_ctrl_asserts u_conversion_clock_select_ctrl_asserts (.i_sys_clk, .i_rst, .i_start, .i_cfg,
    .o_busy, .o_sampling, .o_done, .o_result);
`default_nettype wire

// *** verification/conversion_clock_select_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module conversion_clock_select_ctrl_tb
    import conversion_clock_select_pkg::*;
;
    logic              i_sys_clk = 1'b0;
    logic              i_rst = 1'b1;
    logic              i_start = 1'b0;
    conversion_clock_select_cfg_t        i_cfg = '0;
    conversion_clock_select_ain_t        i_ain;
    logic signed [11:0] lvl = 12'sh000;
    logic              o_busy;
    logic              o_sampling;
    logic              o_done;
    logic [9:0]        o_result;
    int                mismatches = 0;
    int                check_count = 0;
    int                seed = 32'h00E9BB6B;
    conversion_clock_select_src u_conversion_clock_select_src (.i_lvl(lvl), .o_ain(i_ain));
    conversion_clock_select_ctrl u_conversion_clock_select_ctrl (.i_sys_clk, .i_rst, .i_start, .i_cfg, .i_ain, .o_busy, .o_sampling,
        .o_done, .o_result);
    always #25 i_sys_clk = ~i_sys_clk;
    function automatic logic [9:0] exp_res(input logic signed [11:0] v);
        return (v < 0) ? CONVERSION_CLOCK_SELECT_CODE_MIN : (v > 12'sh3FF) ? CONVERSION_CLOCK_SELECT_CODE_FULL : v[9:0];
    endfunction : exp_res
    function automatic int exp_len(input conversion_clock_select_cfg_t c);
        int cc;
        cc = (c[3:2] == 2'h2) ? 48 : (c[3:2] == 2'h3) ? 24 : 12;
        return cc * (14 + 2 * (1 << c[1:0])) + 3;
    endfunction : exp_len
    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check
    // The level and the select fields are both disturbed mid-run; neither may leak in.
    task automatic run_conv(input conversion_clock_select_cfg_t c, input logic signed [11:0] v);
        int n;
        @(negedge i_sys_clk);
        i_cfg = c;
        lvl = v;
        i_start = 1'b1;
        n = 0;
        while (o_done !== 1'b1 && n < 3000)
        begin
            @(negedge i_sys_clk);
            n++;
            i_start = 1'b0;
            i_cfg = ~c;
            if (o_busy === 1'b1 && o_sampling === 1'b0)
                lvl = ~v;
        end
        if (n >= 3000)
        begin
            mismatches++;
            wrap_up();
        end
        check(n == exp_len(c), "conversion length");
        check(o_result === exp_res(v), "result code");
    endtask : run_conv
    initial
    begin
        static logic signed [11:0] corner [4] = '{-12'sd5, 12'sd1100, 12'sd0, 12'sd1023};
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_rst = 1'b0;
        for (int k = 0; k < 16; k++)
            run_conv(conversion_clock_select_cfg_t'(k[3:0]), (k < 4) ? corner[k] : 12'($random(seed) % 1300));
        @(negedge i_sys_clk);
        i_rst = 1'b1;
        @(negedge i_sys_clk);
        check(o_busy === 1'b0 && o_result === 10'h000, "reset state");
        i_rst = 1'b0;
        run_conv(4'hF, -12'sd1);
        wrap_up();
    end
endmodule : conversion_clock_select_ctrl_tb
`default_nettype wire
